// *** core/asfe_link.sv ***
// Serial clock side: input shifting, response launch, pass-through
`timescale 1ns/1ps
module asfe_link (
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic [127:0] i_resp,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [127:0] o_rx_shift,
  output logic [7:0] o_rx_count,
  output logic o_frame_toggle
);
  logic armed_reg; // First clock of a frame still to come
  logic [7:0] tx_cnt_reg; // Falling edges seen this frame, stops counting at 128

  // Armed by deselect; cleared by first rising edge
  always_ff @(posedge i_sclk or posedge i_cs_n or posedge i_reset) begin
    if (i_reset || i_cs_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // Input shifter, MSB first, captured on rising edge
  // Last 128 bits held; last 32 bits form the command
  always_ff @(posedge i_sclk) begin
    o_rx_shift <= {o_rx_shift[126:0], i_mosi};
  end

  // Clock count and frame marker, stable while deselected
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_count <= 8'h00;
      o_frame_toggle <= 1'b0;
    end else if (armed_reg) begin
      o_rx_count <= 8'h01;
      o_frame_toggle <= ~o_frame_toggle;
    end else if (o_rx_count != asfe_pkg::CNT_MAX) begin
      o_rx_count <= o_rx_count + 8'h01;
    end
  end

  // Launch on falling edge; chip select releases the line
  // Beyond one long response the received stream passes through
  always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_reset) begin
    if (i_reset || i_cs_n) begin
      tx_cnt_reg <= 8'h00;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= 1'b1;
      if (tx_cnt_reg < asfe_pkg::LONG_LEN) begin
        o_miso <= i_resp[7'(8'h7f - tx_cnt_reg)];
        tx_cnt_reg <= tx_cnt_reg + 8'h01;
      end else begin
        o_miso <= o_rx_shift[127];
      end
    end
  end
endmodule // asfe_link

// *** core/asfe_top.sv ***
// Top of the serial frame engine: decode, registers, response build
`timescale 1ns/1ps
module asfe_top #(
  parameter int GP_DEPTH = 16 // General register bytes
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_MOSI,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic [23:0] I_CURRENT_SAMPLE_WORD,
  input wire logic [23:0] I_VOLTAGE_ONE_SAMPLE_WORD,
  input wire logic [23:0] I_VOLTAGE_TWO_SAMPLE_WORD,
  input wire logic I_SAMPLE_READY_SIGNAL,
  input wire logic [7:0] I_PRIMARY_STATUS_BITS,
  input wire logic [7:0] I_SECONDARY_STATUS_BYTE,
  input wire logic I_IRQ_PENDING,
  output logic [7:0] O_PRIMARY_CONFIG_REGISTER,
  output logic [7:0] O_FILTER_CONFIG_REGISTER
);
  localparam int GP_IDX_W = $clog2(GP_DEPTH);

  // Config bytes need two slots; address space ends at 0xff
  if (GP_DEPTH < 2 || GP_DEPTH > 64) begin : g_bad_depth
    $error("GP_DEPTH must lie between 2 and 64");
  end

  // Link side wires
  logic [127:0] rx_shift; // Received stream
  logic [7:0] rx_count; // Clocks in last frame, saturating at 255
  logic frame_toggle; // Flips once per clocked frame
  logic [127:0] resp_reg; // Response for next frame

  // Serial clock logic lives in its own domain
  asfe_link u_link (
    .i_reset(I_RESET),
    .i_sclk(I_SCLK),
    .i_cs_n(I_CS_N),
    .i_mosi(I_MOSI),
    .i_resp(resp_reg),
    .o_miso(O_MISO),
    .o_miso_oe(O_MISO_OE),
    .o_rx_shift(rx_shift),
    .o_rx_count(rx_count),
    .o_frame_toggle(frame_toggle)
  );

  // Chip select synchroniser and frame state
  logic [2:0] cs_sync_reg; // Three stages, first read only by second
  logic cs_level_reg; // Filtered chip select level
  asfe_pkg::asfe_state_type state_reg;
  logic frame_end; // Deselect seen after a frame
  logic seen_toggle_reg; // Marker value at last frame end

  // Command decode
  asfe_pkg::asfe_cmd_type cmd_in; // Last 32 bits received
  asfe_pkg::asfe_cmd_type cmd_reg; // Command owning next response
  logic cmd_valid; // Frame carried a full command
  logic crc_ok; // Checksum matched
  logic crc_bad; // Mismatch while checking enabled
  logic exec; // Command is acted on
  logic wr_exec; // Write acted on
  logic err_reg; // Last command failed checksum
  logic build_reg; // Response build pulse

  // Register state
  logic [7:0] gp_mem [GP_DEPTH]; // General bytes incl. config
  asfe_pkg::asfe_samples_type samples_reg; // Sample words
  logic crc_err_reg; // Sticky checksum error flag
  logic [7:0] primary_status_byte; // Primary status byte view
  logic [1:0] dbg_mode; // Stream debug select
  logic smp_wr; // Write lands in a sample byte

  // Response assembly
  logic [7:0] echo; // Echo byte
  logic [111:0] long_body; // Long response before checksum
  logic [31:0] short_body; // Short response before checksum
  logic [127:0] resp_next;

  // Command checksum, MSB first
  function automatic logic [7:0] crc8_calc(input logic [23:0] d);
    logic [7:0] c;
    c = asfe_pkg::CRC8_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ asfe_pkg::CRC8_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ asfe_pkg::CRC8_XOR;
  endfunction

  // Response checksum over the first n bits of d
  function automatic logic [15:0] crc16_calc(input logic [111:0] d, input int n);
    logic [15:0] c;
    c = asfe_pkg::CRC16_INIT;
    for (int i = 0; i < 112; i++) begin
      if (i < n) begin
        if (c[15] ^ d[111 - i]) begin
          c = {c[14:0], 1'b0} ^ asfe_pkg::CRC16_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
    end
    return c;
  endfunction

  // Address falls in the general bytes
  function automatic logic is_gp(input logic [7:0] a);
    return ({1'b0, a} >= {1'b0, asfe_pkg::ADDR_GP_BASE}) &&
      ({1'b0, a} < {1'b0, asfe_pkg::ADDR_GP_BASE} + 9'(GP_DEPTH));
  endfunction

  // Index into the general bytes
  function automatic logic [GP_IDX_W-1:0] gp_idx(input logic [7:0] a);
    logic [7:0] o;
    o = a - asfe_pkg::ADDR_GP_BASE;
    return o[GP_IDX_W-1:0];
  endfunction

  // Register read view; unmapped bytes read zero
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [71:0] s;
    logic [7:0] r;
    s = samples_reg;
    r = 8'h00;
    if (a <= asfe_pkg::ADDR_SMP_LAST) begin
      r = s[71 - 8 * int'(a) -: 8];
    end else if (a == asfe_pkg::ADDR_PRIMARY_STATUS_BYTE) begin
      r = primary_status_byte;
    end else if (a == asfe_pkg::ADDR_SECONDARY_STATUS_BYTE) begin
      r = I_SECONDARY_STATUS_BYTE;
    end else if (is_gp(a)) begin
      r = gp_mem[gp_idx(a)];
    end
    return r;
  endfunction

  // Chip select enters through three stages
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cs_sync_reg <= 3'h7;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], I_CS_N};
    end
  end

  // Level accepted once stages two and three agree
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cs_level_reg <= 1'b1;
    end else if (cs_sync_reg[1] == cs_sync_reg[2]) begin
      cs_level_reg <= cs_sync_reg[2];
    end
  end

  // Frame tracking; only deselect ends a frame
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= asfe_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        asfe_pkg::ST_IDLE: begin
          if (!cs_level_reg) begin
            state_reg <= asfe_pkg::ST_FRAME;
          end
        end
        asfe_pkg::ST_FRAME: begin
          if (cs_level_reg) begin
            state_reg <= asfe_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= asfe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign frame_end = (state_reg == asfe_pkg::ST_FRAME) && cs_level_reg;

  // Link words are still while deselected, so they are read here
  // A frame with no clocks leaves the marker alone and is ignored
  always_comb begin
    cmd_in = rx_shift[31:0];
    cmd_valid = frame_end && (frame_toggle != seen_toggle_reg) &&
      (rx_count >= asfe_pkg::CMD_LEN);
    crc_ok = crc8_calc(cmd_in[31:8]) == cmd_in.crc;
    crc_bad = cmd_valid && !crc_ok &&
      gp_mem[asfe_pkg::CFG0_IDX][asfe_pkg::CRC_EN_BIT];
    exec = cmd_valid && !crc_bad;
    wr_exec = exec && !cmd_in.rd;
    smp_wr = wr_exec && (cmd_in.addr <= asfe_pkg::ADDR_SMP_LAST);
  end

  // Marker copy, command latch and build pulse
  // Reserved bits 29:24 are not decoded
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      seen_toggle_reg <= 1'b0;
      cmd_reg <= '0;
      err_reg <= 1'b0;
      build_reg <= 1'b0;
    end else begin
      build_reg <= cmd_valid;
      if (frame_end) begin
        seen_toggle_reg <= frame_toggle;
      end
      if (cmd_valid) begin
        cmd_reg <= cmd_in;
        err_reg <= crc_bad;
      end
    end
  end

  // Sticky checksum error; write one clears, set wins
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      crc_err_reg <= 1'b0;
    end else if (crc_bad) begin
      crc_err_reg <= 1'b1;
    end else if (wr_exec && cmd_in.addr == asfe_pkg::ADDR_PRIMARY_STATUS_BYTE &&
        cmd_in.data[asfe_pkg::ST0_CRC_ERR]) begin
      crc_err_reg <= 1'b0;
    end
  end

  // Primary status view with the error flag inserted
  always_comb begin
    primary_status_byte = I_PRIMARY_STATUS_BITS;
    primary_status_byte[asfe_pkg::ST0_CRC_ERR] = crc_err_reg;
  end

  // General bytes; write completes once the frame that carries it ends
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      for (int i = 0; i < GP_DEPTH; i++) begin
        gp_mem[i] <= 8'h00;
      end
      gp_mem[asfe_pkg::CFG0_IDX] <= asfe_pkg::PRIMARY_CONFIG_REGISTER_RESET;
      gp_mem[asfe_pkg::FILT_IDX] <= asfe_pkg::FILT_RESET;
    end else if (wr_exec && is_gp(cmd_in.addr)) begin
      gp_mem[gp_idx(cmd_in.addr)] <= cmd_in.data;
    end
  end

  assign O_PRIMARY_CONFIG_REGISTER = gp_mem[asfe_pkg::CFG0_IDX];
  assign O_FILTER_CONFIG_REGISTER = gp_mem[asfe_pkg::FILT_IDX];
  assign dbg_mode = gp_mem[asfe_pkg::CFG0_IDX][asfe_pkg::DBG_LO +: 2];

  // Sample words; a write beats a ready event in the same cycle
  // so the written value is where counting resumes
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      samples_reg <= '0;
    end else if (smp_wr) begin
      samples_reg[71 - 8 * int'(cmd_in.addr) -: 8] <= cmd_in.data;
    end else if (I_SAMPLE_READY_SIGNAL) begin
      case (dbg_mode)
        asfe_pkg::DBG_NORMAL: begin
          samples_reg.cur <= I_CURRENT_SAMPLE_WORD;
          samples_reg.v1 <= I_VOLTAGE_ONE_SAMPLE_WORD;
          samples_reg.v2 <= I_VOLTAGE_TWO_SAMPLE_WORD;
        end
        asfe_pkg::DBG_COUNT: begin
          samples_reg.cur <= samples_reg.cur + 24'h000001;
          samples_reg.v1 <= samples_reg.v1 + 24'h000001;
          samples_reg.v2 <= samples_reg.v2 + 24'h000001;
        end
        default: begin
          samples_reg <= samples_reg;
        end
      endcase
    end
  end

  // Response content, built after the command took effect
  always_comb begin
    echo = {cmd_reg.rd, cmd_reg.long_fmt, 4'h0, err_reg, I_IRQ_PENDING};
    long_body = {echo, samples_reg.cur, primary_status_byte, samples_reg.v1,
      I_SECONDARY_STATUS_BYTE, samples_reg.v2, 16'h0000};
    if (cmd_reg.rd) begin
      long_body[15:0] = {read_byte(cmd_reg.addr + 8'h01),
        read_byte(cmd_reg.addr)};
    end else begin
      long_body[15:0] = {cmd_reg.addr, read_byte(cmd_reg.addr)};
    end
    short_body = {echo, 24'h000000};
    if (!cmd_reg.rd) begin
      short_body[23:0] = {cmd_reg.addr, read_byte(cmd_reg.addr), primary_status_byte};
    end else if (cmd_reg.addr <= asfe_pkg::ADDR_SMP_LAST) begin
      if (cmd_reg.addr < 8'h03) begin
        short_body[23:0] = samples_reg.cur;
      end else if (cmd_reg.addr < 8'h06) begin
        short_body[23:0] = samples_reg.v1;
      end else begin
        short_body[23:0] = samples_reg.v2;
      end
    end else begin
      short_body[23:0] = {read_byte(cmd_reg.addr + 8'h01),
        read_byte(cmd_reg.addr), primary_status_byte};
    end
    if (cmd_reg.long_fmt) begin
      resp_next = {long_body,
        crc16_calc(long_body, asfe_pkg::CRC16_LONG_N)};
    end else begin
      resp_next = {short_body,
        crc16_calc({short_body, 80'h0}, asfe_pkg::CRC16_SHORT_N),
        80'h0};
    end
  end

  // Response held still across the next frame
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      resp_reg <= '0;
    end else if (build_reg) begin
      resp_reg <= resp_next;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  a_crc_err_set: assert property (crc_bad |=> crc_err_reg ##1 crc_err_reg)
    else $error("checksum error flag not set");
  a_cmd_discard: assert property (crc_bad |=> $stable(gp_mem[asfe_pkg::CFG0_IDX]) &&
      ($past(I_SAMPLE_READY_SIGNAL) || $stable(samples_reg)))
    else $error("failed command changed state");
  a_cfg_write: assert property (wr_exec && cmd_in.addr == asfe_pkg::ADDR_GP_BASE
      |=> O_PRIMARY_CONFIG_REGISTER == $past(cmd_in.data))
    else $error("write did not land");
  a_echo_dir: assert property (cmd_valid |=> ##1
      resp_reg[127] == $past(cmd_in.rd, 2) && resp_reg[126] == $past(cmd_in.long_fmt, 2))
    else $error("echo does not match command");
  a_echo_rsvd: assert property (build_reg |=> resp_reg[125:122] == 4'h0)
    else $error("echo reserved bits nonzero");
  a_long_crc: assert property (build_reg && cmd_reg.long_fmt |=>
      resp_reg[15:0] == crc16_calc(resp_reg[127:16], asfe_pkg::CRC16_LONG_N))
    else $error("long checksum wrong");
  a_short_crc: assert property (build_reg && !cmd_reg.long_fmt |=>
      resp_reg[95:80] == crc16_calc({resp_reg[127:96], 80'h0},
      asfe_pkg::CRC16_SHORT_N) && resp_reg[79:0] == 80'h0)
    else $error("short checksum wrong");
  a_static_hold: assert property (dbg_mode == asfe_pkg::DBG_STATIC && !smp_wr
      |=> $stable(samples_reg))
    else $error("static samples moved");
  a_count_step: assert property (dbg_mode == asfe_pkg::DBG_COUNT && !smp_wr &&
      I_SAMPLE_READY_SIGNAL |=> samples_reg.v2 == $past(samples_reg.v2) + 24'h000001)
    else $error("count mode did not step");
  a_resp_still: assert property (state_reg == asfe_pkg::ST_FRAME && !cs_level_reg
      |=> $stable(resp_reg))
    else $error("response changed inside a frame");
endmodule // asfe_top

// *** pkg/asfe_pkg.sv ***
// Package: constants and carrier types of the serial frame engine
package asfe_pkg;
  // Frame sizes and counters
  localparam logic [7:0] LONG_LEN = 8'h80;
  localparam logic [7:0] CMD_LEN = 8'h20;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int CRC16_LONG_N = 112;
  localparam int CRC16_SHORT_N = 32;
  // Checksum constants
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'h00;
  localparam logic [7:0] CRC8_XOR = 8'h55;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  // Register addresses
  localparam logic [7:0] ADDR_SMP_LAST = 8'h08;
  localparam logic [7:0] ADDR_PRIMARY_STATUS_BYTE = 8'h10;
  localparam logic [7:0] ADDR_SECONDARY_STATUS_BYTE = 8'h11;
  localparam logic [7:0] ADDR_GP_BASE = 8'h20;
  localparam int CFG0_IDX = 0;
  localparam int FILT_IDX = 1;
  // Field positions and reset values
  localparam int CRC_EN_BIT = 1;
  localparam int DBG_LO = 2;
  localparam int ST0_CRC_ERR = 1;
  localparam logic [7:0] PRIMARY_CONFIG_REGISTER_RESET = 8'h02;
  localparam logic [7:0] FILT_RESET = 8'h00;
  // Stream debug encodings
  localparam logic [1:0] DBG_NORMAL = 2'h0;
  localparam logic [1:0] DBG_STATIC = 2'h1;
  localparam logic [1:0] DBG_COUNT = 2'h2;
  // Command word as received
  typedef struct packed {
    logic rd;
    logic long_fmt;
    logic [5:0] rsvd;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] crc;
  } asfe_cmd_type;
  // Three sample words, current first
  typedef struct packed {
    logic [23:0] cur;
    logic [23:0] v1;
    logic [23:0] v2;
  } asfe_samples_type;
  // Frame handling states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FRAME
  } asfe_state_type;
endpackage

// *** tb/asfe_host.sv ***
// Host model: serial main that frames commands and collects responses
`timescale 1ns/1ps
module asfe_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // Idle: deselected, clock parked high between frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Command checksum over the upper 24 bits
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = asfe_pkg::CRC8_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? asfe_pkg::CRC8_POLY : 8'h00);
    end
    return c ^ asfe_pkg::CRC8_XOR;
  endfunction
  // Command word: operation, format, zero field, address, payload, checksum
  function automatic logic [31:0] mk_cmd(input logic rd, input logic lng,
                                         input logic [7:0] addr, input logic [7:0] data);
    logic [23:0] h;
    h = {rd, lng, 6'h00, addr, data};
    return {h, crc8(h)};
  endfunction
  // One frame of n clocks; tx[n-1:0] goes out first bit first, so the command
  // always sits in the final 32 clocks; the caller picks n from the last request
  task automatic frame(input int n, input logic [255:0] tx, output logic [255:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    #83; // Odd lead keeps serial edges off the system clock grid when the frame starts on a clock edge
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      #80;
      o_sclk = 1'b1;
      rx = {rx[254:0], i_miso}; // Sampled on rise, device launched on fall
      #80;
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line must not show a stale bit
    #200; // Deselect gap well above the 80 ns minimum
  endtask
endmodule // asfe_host

// *** tb/asfe_top_tb.sv ***
// Testbench of the serial frame engine driven by the host model
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH at %0t ns: %s", $time, m); end end
module asfe_top_tb;
  localparam logic [23:0] CA = 24'h0a0b0c; // Current sample loaded first
  localparam logic [23:0] VA = 24'h102030; // Voltage one sample
  localparam logic [23:0] WA = 24'h405060; // Voltage two sample
  localparam logic [7:0] ST0 = 8'h5c; // Status input, error bit clear
  localparam logic [7:0] ST1 = 8'h3c; // Secondary status
  logic clk = 1'b0; // System clock
  logic rst = 1'b0; // Reset, raised at time zero so its edge is seen
  logic [23:0] cur = CA;
  logic [23:0] v1 = VA;
  logic [23:0] v2 = WA;
  logic rdy = 1'b0; // Ready pulse
  logic [7:0] st0 = ST0;
  logic [7:0] st1 = ST1;
  logic irq = 1'b1; // Pending interrupt level
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [7:0] cfg0, cfgf;
  logic [255:0] rx; // Bits collected by the host
  int n_mismatch = 0;
  int n_tests = 0;
  wire miso_line = miso_oe ? miso : 1'bz; // Released data line floats
  // 125 MHz system clock
  always #4 clk = ~clk;
  asfe_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));
  asfe_top uut (.I_CLK(clk), .I_RESET(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE(miso_oe), .I_CURRENT_SAMPLE_WORD(cur),
    .I_VOLTAGE_ONE_SAMPLE_WORD(v1), .I_VOLTAGE_TWO_SAMPLE_WORD(v2),
    .I_SAMPLE_READY_SIGNAL(rdy), .I_PRIMARY_STATUS_BITS(st0),
    .I_SECONDARY_STATUS_BYTE(st1), .I_IRQ_PENDING(irq),
    .O_PRIMARY_CONFIG_REGISTER(cfg0), .O_FILTER_CONFIG_REGISTER(cfgf));
  // Response checksum over the low n bits of d
  function automatic logic [15:0] crc16(input logic [111:0] d, input int n);
    logic [15:0] c;
    c = asfe_pkg::CRC16_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? asfe_pkg::CRC16_POLY : 16'h0000);
    end
    return c;
  endfunction
  // Echo byte and status byte as the device should report them
  function automatic logic [7:0] echo(input logic rd, lng, err, q);
    return {rd, lng, 4'h0, err, q};
  endfunction
  function automatic logic [7:0] s0(input logic err);
    return {ST0[7:2], err, ST0[0]};
  endfunction
  // Whole long response with its trailing checksum
  function automatic logic [127:0] lresp(input logic [7:0] e, input logic [23:0] c, a, b,
                                         input logic [7:0] s, hi, lo);
    logic [111:0] h;
    h = {e, c, s, a, ST1, b, hi, lo};
    return {h, crc16(h, 112)};
  endfunction
  // One ready event in the system domain
  task automatic ready_pulse();
    @(posedge clk) rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Reset values and released data line
  task automatic t_reset();
    `CHK(miso_oe, 1'b0, "output enable after reset")
    `CHK(cfg0, 8'h02, "config reset value")
    `CHK(cfgf, 8'h00, "filter config reset value")
    $display("Done: reset values");
  endtask
  // First frame after reset answers zeros; the write lands at once
  task automatic t_first();
    ready_pulse();
    host.frame(128, host.mk_cmd(1'b0, 1'b1, 8'h20, 8'h06), rx);
    `CHK(rx[127:0], 128'h0, "first response")
    `CHK(cfg0, 8'h06, "config write")
    `CHK(miso_oe, 1'b0, "release after frame")
    $display("Done: first frame");
  endtask
  // Long write response; new samples wait for a ready event
  task automatic t_long_write();
    logic [127:0] e;
    e = lresp(echo(0, 1, 0, 1), CA, VA, WA, s0(0), 8'h20, 8'h06);
    @(posedge clk) begin cur <= ~CA; v1 <= ~VA; v2 <= ~WA; end
    host.frame(128, host.mk_cmd(1'b1, 1'b0, 8'h00, 8'h00), rx);
    `CHK(rx[127:0], e, "lw")
    $display("Done: long write response");
  endtask
  // Static mode holds samples; 48-clock short read of a sample word
  task automatic t_short_static();
    logic [31:0] h;
    ready_pulse();
    h = {echo(1, 0, 0, 1), CA};
    host.frame(48, host.mk_cmd(1'b0, 1'b0, 8'h20, 8'h0a), rx);
    `CHK(rx[47:0], {h, crc16({80'h0, h}, 32)}, "short sample read")
    `CHK(cfg0, 8'h0a, "count mode set")
    $display("Done: short static read");
  endtask
  // 32-clock short write response; the next command carries a bad checksum
  task automatic t_short_write();
    ready_pulse();
    ready_pulse();
    @(posedge clk) irq <= 1'b0;
    host.frame(32, host.mk_cmd(1'b0, 1'b1, 8'h21, 8'h33) ^ 32'h1, rx);
    `CHK(rx[31:0], {echo(0, 0, 0, 1), 8'h20, 8'h0a, s0(0)}, "short write")
    `CHK(cfgf, 8'h00, "bad command discarded")
    $display("Done: short write and bad checksum");
  endtask
  // Error echo after the discarded command
  task automatic t_bad_crc();
    host.frame(128, host.mk_cmd(1'b1, 1'b1, 8'h10, 8'h00), rx);
    `CHK(rx[127:120], echo(0, 1, 1, 0), "error echo")
    `CHK(rx[95:88], s0(1), "error status flag")
    $display("Done: checksum error");
  endtask
  // Two-device chain: own long response, then the first 128 input bits return
  task automatic t_daisy();
    logic [127:0] pat;
    logic [127:0] e;
    pat = 128'h0123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
    // Count mode stepped the held words twice; inputs are not loaded
    e = lresp(echo(1, 1, 0, 0), CA + 24'h2, VA + 24'h2, WA + 24'h2, s0(1), ST1, s0(1));
    host.frame(256, {pat, 96'h0, host.mk_cmd(1'b0, 1'b1, 8'h10, 8'h02)}, rx);
    `CHK(rx[255:128], e, "lr")
    `CHK(rx[127:0], pat, "chain pass-through")
    $display("Done: daisy chain");
  endtask
  // Cleared error flag in a long write echo, then a 32-clock short register read
  task automatic t_clear();
    logic [127:0] e;
    e = lresp(echo(0, 1, 0, 0), CA + 24'h2, VA + 24'h2, WA + 24'h2, s0(0), 8'h10, s0(0));
    host.frame(128, host.mk_cmd(1'b1, 1'b0, 8'h20, 8'h00), rx);
    `CHK(rx[127:0], e, "error flag cleared")
    host.frame(32, host.mk_cmd(1'b1, 1'b1, 8'h21, 8'h00), rx);
    `CHK(rx[31:0], {echo(1, 0, 0, 0), 8'h00, 8'h0a, s0(0)}, "short register read")
    $display("Done: error clear and short register read");
  endtask
  // Counts, verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_first();
    t_long_write();
    t_short_static();
    t_short_write();
    t_bad_crc();
    t_daisy();
    t_clear();
    close_out();
  end
  // Watchdog: frames need about 150 us, so twice that is a hang
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
endmodule // asfe_top_tb
